// File: verilog/sync_coast_clamp_control.sv
// Sync shaping, coast window and clamp timing control for a capture front end.
// Assumes all pins are synchronous to mclk_i, one pixel per enabled cycle,
// and byte registers written over a simple address/data control port.
`timescale 1ns/1ps
`include "sync_coast_clamp_map.svh"

module sync_coast_clamp_control
  import sync_coast_clamp_pkg::*;
#(
  parameter int RUN_W = 20,
  parameter int LINE_W = 12
) (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  output logic [7:0] reg_rdata_o,
  // Incoming syncs and external timing pins
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic sep_vsync_i,
  input wire logic sync_on_green_i,
  input wire logic coast_pin_i,
  input wire logic clamp_pin_i,
  input wire logic sync_filter_en_i,
  // Shaped outputs
  output logic vsync_o,
  output logic coast_o,
  output logic clamp_o,
  output logic [2:0] clamp_midscale_o,
  output logic green_sync_output_o,
  output logic [4:0] sog_threshold_o,
  output logic auto_offset_en_o,
  output logic offset_update_o
);

  // Programmed registers
  logic [7:0] vsync_control_q;
  logic [7:0] vsync_width_q;
  logic [7:0] coast_lead_lines_q;
  logic [7:0] coast_trail_lines_q;
  logic [7:0] coast_clamp_select_q;
  logic [7:0] clamp_start_delay_q;
  logic [7:0] clamp_width_q;
  logic [7:0] clamp_offset_control_q;
  logic [7:0] green_sync_control_q;

  // Register writes, stored exactly as written
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      vsync_control_q <= `RST_VSYNC_CONTROL;
      vsync_width_q <= `RST_VSYNC_WIDTH;
      coast_lead_lines_q <= `RST_COAST_LEAD_LINES;
      coast_trail_lines_q <= `RST_COAST_TRAIL_LINES;
      coast_clamp_select_q <= `RST_COAST_CLAMP_SELECT;
      clamp_start_delay_q <= `RST_CLAMP_START_DELAY;
      clamp_width_q <= `RST_CLAMP_WIDTH;
      clamp_offset_control_q <= `RST_CLAMP_OFFSET_CONTROL;
      green_sync_control_q <= `RST_GREEN_SYNC_CONTROL;
    end else if (ce_i && reg_wr_i) begin
      case (reg_addr_i)
        `OFS_VSYNC_CONTROL: vsync_control_q <= reg_wdata_i;
        `OFS_VSYNC_WIDTH: vsync_width_q <= reg_wdata_i;
        `OFS_COAST_LEAD_LINES: coast_lead_lines_q <= reg_wdata_i;
        `OFS_COAST_TRAIL_LINES: coast_trail_lines_q <= reg_wdata_i;
        `OFS_COAST_CLAMP_SELECT: coast_clamp_select_q <= reg_wdata_i;
        `OFS_CLAMP_START_DELAY: clamp_start_delay_q <= reg_wdata_i;
        `OFS_CLAMP_WIDTH: clamp_width_q <= reg_wdata_i;
        `OFS_CLAMP_OFFSET_CONTROL: clamp_offset_control_q <= reg_wdata_i;
        `OFS_GREEN_SYNC_CONTROL: green_sync_control_q <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Read selection; unmapped sub-addresses read zero
  logic [7:0] rd_sel;
  assign rd_sel =
      (reg_addr_i == `OFS_VSYNC_CONTROL) ? vsync_control_q :
      (reg_addr_i == `OFS_VSYNC_WIDTH) ? vsync_width_q :
      (reg_addr_i == `OFS_COAST_LEAD_LINES) ? coast_lead_lines_q :
      (reg_addr_i == `OFS_COAST_TRAIL_LINES) ? coast_trail_lines_q :
      (reg_addr_i == `OFS_COAST_CLAMP_SELECT) ? coast_clamp_select_q :
      (reg_addr_i == `OFS_CLAMP_START_DELAY) ? clamp_start_delay_q :
      (reg_addr_i == `OFS_CLAMP_WIDTH) ? clamp_width_q :
      (reg_addr_i == `OFS_CLAMP_OFFSET_CONTROL) ? clamp_offset_control_q :
      (reg_addr_i == `OFS_GREEN_SYNC_CONTROL) ? green_sync_control_q : 8'h00;

  // Read data registered one cycle after the address
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      reg_rdata_o <= rd_sel;
    end
  end

  // Polarity detection: 0 hsync, 1 vsync source, 2 coast pin, 3 clamp pin.
  // A pulse is the shorter of the two levels, so a high run shorter than
  // the low run means active high. Counters saturate on idle lines.
  localparam int NPOL = 4;
  logic [NPOL-1:0] raw_in;
  logic [NPOL-1:0] raw_q;
  logic [NPOL-1:0] det_pos;
  logic [RUN_W-1:0] run_q [NPOL];
  logic [RUN_W-1:0] hi_len_q [NPOL];
  logic [RUN_W-1:0] lo_len_q [NPOL];
  logic vs_src;

  assign raw_in = {clamp_pin_i, coast_pin_i, vs_src, hsync_i};

  for (genvar g = 0; g < NPOL; g++) begin : g_pol
    always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
        raw_q[g] <= 1'b0;
        run_q[g] <= '0;
        hi_len_q[g] <= '0;
        lo_len_q[g] <= '1;
      end else if (ce_i) begin
        raw_q[g] <= raw_in[g];
        if (raw_in[g] != raw_q[g]) begin
          run_q[g] <= '0;
          if (raw_q[g]) begin
            hi_len_q[g] <= run_q[g];
          end else begin
            lo_len_q[g] <= run_q[g];
          end
        end else if (run_q[g] != '1) begin
          run_q[g] <= run_q[g] + 1'b1;
        end
      end
    end
    assign det_pos[g] = (hi_len_q[g] <= lo_len_q[g]);
  end

  // Fold a raw level to active high under a chosen polarity
  function automatic logic to_active(input logic lvl, input pol_t pol);
    to_active = (pol == POL_POS) ? lvl : ~lvl;
  endfunction : to_active

  // Vsync source and polarity choice
  logic vs_pol_pos;
  logic coast_pol_pos;
  logic clamp_pol_pos;
  assign vs_src = (vsync_control_q[`VC_SRC_OVR] && vsync_control_q[`VC_SRC_SEL]) ?
                  sep_vsync_i : vsync_i;
  assign vs_pol_pos = vsync_control_q[`VC_IN_POL_OVR] ? vsync_control_q[`VC_IN_POL] :
                      det_pos[1];
  assign coast_pol_pos = coast_clamp_select_q[`CS_COAST_POL_OVR] ?
                         coast_clamp_select_q[`CS_COAST_POL] : det_pos[2];
  assign clamp_pol_pos = clamp_offset_control_q[`CO_CLAMP_POL_OVR] ?
                         clamp_offset_control_q[`CO_CLAMP_POL] : det_pos[3];

  // Active-high versions of Hsync, the Vsync source and the coast and clamp pins
  logic hs_act;
  logic vs_act;
  logic coast_ext_act;
  logic clamp_ext_act;
  assign hs_act = to_active(hsync_i, pol_t'(det_pos[0]));
  assign vs_act = to_active(vs_src, pol_t'(vs_pol_pos));
  assign coast_ext_act = to_active(coast_pin_i, pol_t'(coast_pol_pos));
  assign clamp_ext_act = to_active(clamp_pin_i, pol_t'(clamp_pol_pos));

  // Hsync edge strobes
  logic hs_q;
  logic hs_lead;
  logic hs_trail;
  assign hs_lead = hs_act && !hs_q;
  assign hs_trail = !hs_act && hs_q;

  // Vsync filter: edges only move on an Hsync leading edge, which keeps the
  // lines-per-frame count exact at the cost of up to one line of latency.
  logic vs_filt_q;
  logic vs_filt;
  logic vs_filt_prev_q;
  logic vs_lead;
  logic vs_trail;
  assign vs_filt = vsync_control_q[`VC_FILT_EN] ? vs_filt_q : vs_act;
  assign vs_lead = vs_filt && !vs_filt_prev_q;
  assign vs_trail = !vs_filt && vs_filt_prev_q;

  // Width in lines; the load cycle counts too, else the pulse is one pixel short
  logic [7:0] vs_dur_q;
  logic vs_shaped;
  assign vs_shaped = vsync_control_q[`VC_DUR_EN] ? (vs_lead || vs_dur_q != 8'h00) :
                     vs_filt;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      hs_q <= 1'b0;
      vs_filt_q <= 1'b0;
      vs_filt_prev_q <= 1'b0;
      vs_dur_q <= 8'h00;
    end else if (ce_i) begin
      hs_q <= hs_act;
      if (hs_lead) begin
        vs_filt_q <= vs_act;
      end
      vs_filt_prev_q <= vs_filt;
      if (vs_lead) begin
        vs_dur_q <= vsync_width_q;
      end else if (hs_lead && vs_dur_q != 8'h00) begin
        vs_dur_q <= vs_dur_q - 8'h01;
      end
    end
  end

  // Output Vsync polarity
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      vsync_o <= 1'b0;
    end else if (ce_i) begin
      vsync_o <= vsync_control_q[`VC_OUT_POL] ? vs_shaped : ~vs_shaped;
    end
  end

  // Line counting for the coast window. The lead window is predicted from
  // the previous frame length, so it is absent on the first frame.
  logic [LINE_W-1:0] line_q;
  logic [LINE_W-1:0] frame_lines_q;
  logic [7:0] trail_q;
  logic pre_win;
  logic coast_int;
  assign pre_win = (frame_lines_q != '0) &&
                   ({{(LINE_W-8){1'b0}}, coast_lead_lines_q} != '0) &&
                   ((line_q + LINE_W'(coast_lead_lines_q)) >= frame_lines_q);
  // Trailing-edge cycle covered before the trail counter has loaded
  assign coast_int = vs_filt || pre_win || (trail_q != 8'h00) ||
                     (vs_trail && coast_trail_lines_q != 8'h00);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      line_q <= '0;
      frame_lines_q <= '0;
      trail_q <= 8'h00;
    end else if (ce_i) begin
      if (vs_lead) begin
        frame_lines_q <= line_q;
        line_q <= '0;
      end else if (hs_lead && line_q != '1) begin
        line_q <= line_q + 1'b1;
      end
      if (vs_trail) begin
        trail_q <= coast_trail_lines_q;
      end else if (hs_lead && trail_q != 8'h00) begin
        trail_q <= trail_q - 8'h01;
      end
    end
  end

  // Coast to the PLL, always active high
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      coast_o <= 1'b0;
    end else if (ce_i) begin
      coast_o <= coast_clamp_select_q[`CS_COAST_SRC] ? coast_ext_act : coast_int;
    end
  end

  // Internal clamp timer
  clamp_timer_if ct ();
  logic ext_clamp_sel;
  assign ext_clamp_sel = coast_clamp_select_q[`CS_CLAMP_SRC];
  assign ct.hs_trail = hs_trail && !ext_clamp_sel;
  assign ct.start_dly = clamp_start_delay_q;
  assign ct.width = clamp_width_q;

  clamp_timer u_clamp_timer (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .ct(ct.tmr)
  );

  // Clamp drives all three channels; per-channel level choice alongside
  logic clamp_sel;
  logic clamp_prev_q;
  assign clamp_sel = ext_clamp_sel ? clamp_ext_act : ct.clamp_act;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      clamp_o <= 1'b0;
      clamp_prev_q <= 1'b0;
      clamp_midscale_o <= 3'h0;
    end else if (ce_i) begin
      clamp_o <= clamp_sel;
      clamp_prev_q <= clamp_sel;
      clamp_midscale_o <= {coast_clamp_select_q[`CS_RED_MID],
                           coast_clamp_select_q[`CS_GREEN_MID],
                           coast_clamp_select_q[`CS_BLUE_MID]};
    end
  end

  // Auto-offset update strobe: one per end of clamp, thinned by the rate, or one per Vsync leading edge
  logic clamp_end;
  logic [1:0] upd_mode;
  logic [5:0] upd_cnt_q;
  logic upd_hit;
  assign clamp_end = !clamp_sel && clamp_prev_q;
  assign upd_mode = clamp_offset_control_q[`CO_UPD_HI:`CO_UPD_LO];
  assign upd_hit =
      (upd_mode == `UPD_EVERY) ? clamp_end :
      (upd_mode == `UPD_16) ? (clamp_end && upd_cnt_q[3:0] == 4'(`UPD_CNT_16)) :
      (upd_mode == `UPD_64) ? (clamp_end && upd_cnt_q == `UPD_CNT_64) :
      vs_lead;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      upd_cnt_q <= 6'h00;
      offset_update_o <= 1'b0;
    end else if (ce_i) begin
      if (clamp_end) begin
        upd_cnt_q <= upd_cnt_q + 6'h01;
      end
      offset_update_o <= upd_hit && clamp_offset_control_q[`CO_AUTO_OFS_EN];
    end
  end

  // Green-sync output polarity and slicer threshold code
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      green_sync_output_o <= 1'b0;
      sog_threshold_o <= 5'h00;
      auto_offset_en_o <= 1'b0;
    end else if (ce_i) begin
      green_sync_output_o <= green_sync_control_q[`GS_OUT_POL] ?
                             sync_on_green_i : ~sync_on_green_i;
      sog_threshold_o <= green_sync_control_q[`GS_THR_HI:`GS_THR_LO];
      auto_offset_en_o <= clamp_offset_control_q[`CO_AUTO_OFS_EN];
    end
  end

endmodule : sync_coast_clamp_control

// File: verilog/sync_coast_clamp_map.svh
// Register offsets, field positions, reset values and small constants
// for the sync, coast and clamp control block.
// Assumes byte-wide registers at their sub-addresses on the control port.
`ifndef SYNC_COAST_CLAMP_MAP_SVH
`define SYNC_COAST_CLAMP_MAP_SVH

// Register sub-addresses
`define OFS_VSYNC_CONTROL 8'h14
`define OFS_VSYNC_WIDTH 8'h15
`define OFS_COAST_LEAD_LINES 8'h16
`define OFS_COAST_TRAIL_LINES 8'h17
`define OFS_COAST_CLAMP_SELECT 8'h18
`define OFS_CLAMP_START_DELAY 8'h19
`define OFS_CLAMP_WIDTH 8'h1A
`define OFS_CLAMP_OFFSET_CONTROL 8'h1B
`define OFS_GREEN_SYNC_CONTROL 8'h1D

// Reset values
`define RST_VSYNC_CONTROL 8'h18
`define RST_VSYNC_WIDTH 8'h0A
`define RST_COAST_LEAD_LINES 8'h00
`define RST_COAST_TRAIL_LINES 8'h00
`define RST_COAST_CLAMP_SELECT 8'h20
`define RST_CLAMP_START_DELAY 8'h08
`define RST_CLAMP_WIDTH 8'h14
`define RST_CLAMP_OFFSET_CONTROL 8'h58
`define RST_GREEN_SYNC_CONTROL 8'h78

// vsync_control fields
`define VC_SRC_OVR 7
`define VC_SRC_SEL 6
`define VC_IN_POL_OVR 5
`define VC_IN_POL 4
`define VC_OUT_POL 3
`define VC_FILT_EN 2
`define VC_DUR_EN 1

// coast_clamp_select fields
`define CS_COAST_SRC 7
`define CS_COAST_POL_OVR 6
`define CS_COAST_POL 5
`define CS_CLAMP_SRC 4
`define CS_RED_MID 3
`define CS_GREEN_MID 2
`define CS_BLUE_MID 1

// clamp_offset_control fields
`define CO_CLAMP_POL_OVR 7
`define CO_CLAMP_POL 6
`define CO_AUTO_OFS_EN 5
`define CO_UPD_HI 4
`define CO_UPD_LO 3

// green_sync_control fields
`define GS_THR_HI 7
`define GS_THR_LO 3
`define GS_OUT_POL 2

// Auto-offset update codes and periods
`define UPD_EVERY 2'h0
`define UPD_16 2'h1
`define UPD_64 2'h2
`define UPD_VSYNC 2'h3
`define UPD_CNT_16 6'hF
`define UPD_CNT_64 6'h3F

`endif

// File: verilog/sync_coast_clamp_pkg.sv
// Types shared by the sync, coast and clamp control modules.
// Assumes the map header is included wherever offsets are needed.
package sync_coast_clamp_pkg;

  // Internal clamp sequencer states
  typedef enum logic [1:0] {
    CLAMP_IDLE,
    CLAMP_WAIT,
    CLAMP_ACTIVE
  } clamp_state_t;

  // Polarity sense used by the input normalisers
  typedef enum logic {
    POL_NEG,
    POL_POS
  } pol_t;

endpackage : sync_coast_clamp_pkg

// File: verilog/clamp_timer_if.sv
// Carrier between the control top and its internal clamp timer.
// Assumes one clock domain; all signals are sampled on mclk_i.
`timescale 1ns/1ps

interface clamp_timer_if;
  logic hs_trail;
  logic [7:0] start_dly;
  logic [7:0] width;
  logic clamp_act;
  logic clamp_done;

  modport ctl (output hs_trail, output start_dly, output width,
               input clamp_act, input clamp_done);
  modport tmr (input hs_trail, input start_dly, input width,
               output clamp_act, output clamp_done);
endinterface : clamp_timer_if

// File: verilog/clamp_timer.sv
// Internal clamp pulse generator counted in pixel periods.
// Assumes one pixel period per enabled mclk_i cycle and an active-high
// Hsync trailing-edge strobe from the control top.
`timescale 1ns/1ps

module clamp_timer
  import sync_coast_clamp_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Link to the control top
  clamp_timer_if.tmr ct
);

  clamp_state_t state_q;
  clamp_state_t state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  // Zero is unsupported; treat it as one so the timer never hangs
  function automatic logic [7:0] at_least_one(input logic [7:0] v);
    at_least_one = (v == 8'h00) ? 8'h01 : v;
  endfunction : at_least_one

  // Next state: wait placement count, then hold for the width count
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      CLAMP_IDLE: begin
        if (ct.hs_trail) begin
          state_d = CLAMP_WAIT;
          cnt_d = at_least_one(ct.start_dly);
        end
      end
      CLAMP_WAIT: begin
        if (cnt_q == 8'h01) begin
          state_d = CLAMP_ACTIVE;
          cnt_d = at_least_one(ct.width);
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      CLAMP_ACTIVE: begin
        if (cnt_q == 8'h01) begin
          state_d = CLAMP_IDLE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: begin
        state_d = CLAMP_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_q <= CLAMP_IDLE;
      cnt_q <= 8'h00;
    end else if (ce_i) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign ct.clamp_act = (state_q == CLAMP_ACTIVE);
  assign ct.clamp_done = (state_q == CLAMP_ACTIVE) && (cnt_q == 8'h01) && ce_i;

endmodule : clamp_timer

// File: test/video_src.sv
// Behavioural video sync source feeding the capture control block.
// Assumes one pixel per mclk_i cycle; syncs are active high and free running.
`timescale 1ns/1ps

module video_src #(
  parameter int LINE = 40,
  parameter int HW = 4,
  parameter int FR = 20,
  parameter int VL = 3
) (
  // Clock
  input wire logic mclk_i,
  // Sync outputs
  output logic hsync_o,
  output logic vsync_o,
  output logic sep_o,
  output logic sog_o
);
  int px = 0;
  int ln = 0;

  // Pixel and line counters; a real source never waits for reset
  always @(posedge mclk_i) begin
    px <= (px == LINE - 1) ? 0 : px + 1;
    if (px == LINE - 1) begin
      ln <= (ln == FR - 1) ? 0 : ln + 1;
    end
  end

  // Short active runs so polarity detection sees active high
  assign hsync_o = (px < HW);
  assign vsync_o = (ln < VL);
  // Separator Vsync sits a few lines later so the source choice is visible
  assign sep_o = (ln >= VL) && (ln < 2 * VL);
  assign sog_o = hsync_o ^ vsync_o;
endmodule : video_src

// File: test/sync_coast_clamp_control_checker.sv
// Assertions on the ports of the sync, coast and clamp control block.
// Assumes binding into the top module; control bytes are shadowed here.
`timescale 1ns/1ps

module sync_coast_clamp_control_checker (
  // Clock, reset, register port
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  // Pins
  input wire logic vsync_i,
  input wire logic sep_vsync_i,
  input wire logic sync_on_green_i,
  input wire logic coast_pin_i,
  input wire logic clamp_pin_i,
  // Outputs watched
  input wire logic vsync_o,
  input wire logic coast_o,
  input wire logic clamp_o,
  input wire logic [2:0] clamp_midscale_o,
  input wire logic green_sync_output_o,
  input wire logic [4:0] sog_threshold_o,
  input wire logic offset_update_o
);
  logic [7:0] vc_q, cs_q, cw_q, co_q, gs_q;

  // Shadow bytes; they move on the same edge as the real registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      vc_q <= 8'h18;
      cs_q <= 8'h20;
      cw_q <= 8'h14;
      co_q <= 8'h58;
      gs_q <= 8'h78;
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == 8'h14) vc_q <= reg_wdata_i;
      if (reg_addr_i == 8'h18) cs_q <= reg_wdata_i;
      if (reg_addr_i == 8'h1A) cw_q <= reg_wdata_i;
      if (reg_addr_i == 8'h1B) co_q <= reg_wdata_i;
      if (reg_addr_i == 8'h1D) gs_q <= reg_wdata_i;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  // Five high cycles then release
  sequence s_pulse5;
    clamp_o [*5] ##1 !clamp_o;
  endsequence
  // Stable internal source and width of five long enough for a fresh pulse
  sequence s_clamp_start;
    $rose(clamp_o) && !cs_q[4] && !$past(cs_q[4], 16) && cw_q == 8'h05
      && $past(cw_q, 16) == 8'h05;
  endsequence

  property p_vsync_pol;
    ce_i && vc_q[5] && vc_q[2:1] == 2'b00 |=>
      vsync_o == (($past(vc_q[7] && vc_q[6]) ? $past(sep_vsync_i) : $past(vsync_i))
        ~^ $past(vc_q[4]) ~^ $past(vc_q[3]));
  endproperty
  a_vsync_pol: assert property (p_vsync_pol) else $error("vsync level wrong");

  property p_coast_ext;
    ce_i && cs_q[7] && cs_q[6] |=> coast_o == ($past(coast_pin_i) ~^ $past(cs_q[5]));
  endproperty
  a_coast_ext: assert property (p_coast_ext) else $error("coast pin path wrong");

  property p_clamp_ext;
    ce_i && cs_q[4] && co_q[7] |=> clamp_o == ($past(clamp_pin_i) ~^ $past(co_q[6]));
  endproperty
  a_clamp_ext: assert property (p_clamp_ext) else $error("clamp pin path wrong");

  property p_clamp_w;
    s_clamp_start |-> s_pulse5;
  endproperty
  a_clamp_w: assert property (p_clamp_w) else $error("clamp width wrong");

  property p_midscale;
    ce_i |=> clamp_midscale_o == $past(cs_q[3:1]);
  endproperty
  a_midscale: assert property (p_midscale) else $error("midscale select wrong");

  property p_green;
    ce_i |=> green_sync_output_o == ($past(sync_on_green_i) ~^ $past(gs_q[2]));
  endproperty
  a_green: assert property (p_green) else $error("green sync level wrong");

  property p_thr;
    ce_i |=> sog_threshold_o == $past(gs_q[7:3]);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold code wrong");

  property p_upd_off;
    !co_q[5] && !$past(co_q[5]) |-> !offset_update_o;
  endproperty
  a_upd_off: assert property (p_upd_off) else $error("update while disabled");
endmodule : sync_coast_clamp_control_checker

bind sync_coast_clamp_control sync_coast_clamp_control_checker
  sync_coast_clamp_control_checker_i (.*);

// File: test/tb.sv
// Self-checking bench for the sync, coast and clamp control block.
// Assumes the video source model and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end

module tb;
  localparam int LINE = 40;
  localparam int FR = 20;
  localparam int VL = 3;
  localparam logic [7:0] ADR [9] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A,
    8'h1B, 8'h1D};
  localparam logic [7:0] RST [9] = '{8'h18, 8'h0A, 8'h00, 8'h00, 8'h20, 8'h08, 8'h14,
    8'h58, 8'h78};
  localparam int GAP [4] = '{LINE, 16 * LINE, 64 * LINE, FR * LINE};
  logic mclk_i = 0;
  logic sys_rst_i = 1;
  logic ce_i = 1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 0;
  logic coast_pin_i = 0;
  logic clamp_pin_i = 0;
  logic sync_filter_en_i = 0;
  logic hsync_i, vsync_i, sep_vsync_i, sync_on_green_i;
  logic [7:0] reg_rdata_o;
  logic vsync_o, coast_o, clamp_o, green_sync_output_o, auto_offset_en_o, offset_update_o;
  logic [2:0] clamp_midscale_o;
  logic [4:0] sog_threshold_o;
  int n_mismatch = 0;
  int tests_run = 0;

  sync_coast_clamp_control sync_coast_clamp_control_i (.*);
  video_src video_src_i (.mclk_i(mclk_i), .hsync_o(hsync_i), .vsync_o(vsync_i),
    .sep_o(sep_vsync_i), .sog_o(sync_on_green_i));

  // 20 MHz clock
  always #25 mclk_i = ~mclk_i;

  // Random external pins, changed just after each edge
  always @(posedge mclk_i) begin
    #2;
    {coast_pin_i, clamp_pin_i} = 2'($urandom);
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #2;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    @(posedge mclk_i);
    #2;
    reg_wr_i = 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    #2;
    reg_addr_i = a;
    @(posedge mclk_i);
    #2;
    d = reg_rdata_o;
  endtask : rd

  function automatic logic pick(input int s);
    case (s)
      0: return clamp_o;
      1: return vsync_o;
      2: return coast_o;
      3: return offset_update_o;
      default: return ~vsync_o;
    endcase
  endfunction : pick

  // High time and rise-to-rise period of one output, bounded
  task automatic run(input int s, output int hi, output int per);
    int n;
    n = 0;
    hi = 0;
    while (pick(s) !== 1'b0 && n < 9000) begin
      @(posedge mclk_i);
      n++;
    end
    while (pick(s) !== 1'b1 && n < 9000) begin
      @(posedge mclk_i);
      n++;
    end
    while (pick(s) === 1'b1 && n < 9000) begin
      @(posedge mclk_i);
      hi++;
      n++;
    end
    per = hi;
    while (pick(s) !== 1'b1 && n < 9000) begin
      @(posedge mclk_i);
      per++;
      n++;
    end
    if (n >= 9000) begin
      n_mismatch++;
      $display("ERROR %0t: output %0d never toggled", $time, s);
    end
  endtask : run

  // Cycles from an Hsync trailing edge to the clamp
  task automatic lat(output int d);
    while (hsync_i !== 1'b1) @(posedge mclk_i);
    while (hsync_i !== 1'b0) @(posedge mclk_i);
    d = 0;
    while (clamp_o !== 1'b1 && d < 300) begin
      @(posedge mclk_i);
      d++;
    end
  endtask : lat

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // Watchdog well beyond the expected run of about 30000 cycles
  initial begin
    repeat (80000) @(posedge mclk_i);
    n_mismatch++;
    final_report();
  end

  // Main sequence
  initial begin
    int hi, per, d1, d2, p, w;
    logic [7:0] r;
    void'($urandom(32'h04866FCB));
    repeat (10) @(posedge mclk_i);
    #2;
    sys_rst_i = 0;
    for (int i = 0; i < 9; i++) begin
      rd(ADR[i], r);
      `CHK(r, RST[i])
    end
    rd(8'h1C, r);
    `CHK(r, 8'h00)
    ce_i = 0;
    wr(8'h16, 8'h55);
    ce_i = 1;
    rd(8'h16, r);
    `CHK(r, 8'h00)
    for (int a = 8'h15; a < 8'h1B; a++) begin
      if (a != 8'h18) begin
        w = $urandom;
        wr(a[7:0], w[7:0]);
        rd(a[7:0], r);
        `CHK(r, w[7:0])
      end
    end
    // Internal clamp: placement offsets and widths
    wr(8'h1A, 8'h05);
    wr(8'h19, 8'h01);
    // Earlier random placement and width can keep the timer busy 510 cycles
    repeat (600) @(posedge mclk_i);
    repeat (2) lat(d1);
    run(0, hi, per);
    `CHK(hi, 5)
    `CHK(per, LINE)
    p = 2 + $urandom % 8;
    w = 1 + $urandom % 8;
    wr(8'h19, p[7:0]);
    wr(8'h1A, w[7:0]);
    repeat (2) lat(d2);
    `CHK(d2 - d1, p - 1)
    run(0, hi, per);
    `CHK(hi, w)
    // Auto-offset update rates
    for (int m = 0; m < 4; m++) begin
      wr(8'h1B, {2'b00, 1'b1, m[1:0], 3'b011});
      run(3, hi, per);
      run(3, hi, per);
      `CHK(per, GAP[m])
      `CHK(auto_offset_en_o, 1'b1)
    end
    wr(8'h1B, 8'h13);
    // Vsync filter, duration and output polarity
    sync_filter_en_i = 1;
    w = 1 + $urandom % 5;
    wr(8'h15, w[7:0]);
    wr(8'h14, 8'h0E);
    repeat (2) run(1, hi, per);
    `CHK(hi, w * LINE)
    `CHK(per, FR * LINE)
    wr(8'h14, 8'h04);
    repeat (2) run(4, hi, per);
    `CHK(hi, VL * LINE)
    // Internal coast window
    p = $urandom % 4;
    w = $urandom % 4;
    wr(8'h14, 8'h0C);
    wr(8'h16, p[7:0]);
    wr(8'h17, w[7:0]);
    wr(8'h18, 8'h00);
    repeat (3) run(2, hi, per);
    `CHK(hi, (VL + p + w) * LINE)
    `CHK(per, FR * LINE)
    // External coast and clamp, both polarities; timer registers ignored
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      wr(8'h18, {2'b11, k[0], 1'b1, r[3:1], 1'b0});
      wr(8'h1B, {1'b1, k[1], 6'b011011});
      wr(8'h1A, r);
      repeat (50) @(posedge mclk_i);
      `CHK(clamp_midscale_o, r[3:1])
    end
    // Green sync threshold and polarity; vsync with forced input sense
    for (int k = 0; k < 2; k++) begin
      r = $urandom;
      wr(8'h1D, {r[7:3], k[0], 2'b00});
      repeat (3) @(posedge mclk_i);
      `CHK(sog_threshold_o, r[7:3])
    end
    wr(8'h14, 8'h28);
    repeat (900) @(posedge mclk_i);
    wr(8'h14, 8'hF8);
    repeat (900) @(posedge mclk_i);
    final_report();
  end
endmodule : tb
